/* design/lfc_pkg.sv */
// Purpose: shared constants of the slow clock controller
// Assumes: byte addresses on a 32-bit Avalon-MM register bus
// Notes: source codes are ordered by accuracy, higher is better
package lfc_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_START_TASK = 12'h008;
  localparam logic [11:0] OFS_STOP_TASK = 12'h00C;
  localparam logic [11:0] OFS_CAL_TASK = 12'h010;
  localparam logic [11:0] OFS_STARTED_EVT = 12'h104;
  localparam logic [11:0] OFS_DONE_EVT = 12'h11C;
  localparam logic [11:0] OFS_START_STATUS = 12'h414;
  localparam logic [11:0] OFS_RUN_STAT = 12'h418;
  localparam logic [11:0] OFS_SRC_LATCHED = 12'h41C;
  localparam logic [11:0] OFS_SRC_SELECT = 12'h518;
  localparam logic [11:0] OFS_KEEP_RUNNING = 12'h520;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int SRC_LSB = 0;
  localparam int SRC_W = 2;
  localparam int RUN_BIT = 16;
  localparam int TASK_BIT = 0;
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic KEEP_RESET = 1'b0;

  // ****************************************
  // sources, ordered rc < crystal < synthesized
  // ****************************************
  typedef enum logic [1:0] {
    SRC_RC = 2'h0,
    SRC_XTAL = 2'h1,
    SRC_SYNTH = 2'h2
  } lfc_src_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_BUSY = 2'b10
  } lfc_cal_t;
endpackage

/* design/lfc_sync.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are levels or toggles from another domain
// Notes: q follows only when stages two and three agree
module lfc_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit, so one settling bit does not hold back the others
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (reset) begin
        q[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        q[i] <= s3_q[i];
      end
    end
  end
endmodule

/* design/lfc_ctrl.sv */
// Purpose: per-core slow clock control instance with Avalon-MM registers
// Assumes: subsystem inputs are asynchronous; peripheral request and
//   system_off come from logic on this clock
// Notes: subsystem events arrive as toggles
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
module lfc_ctrl (
  input wire logic clock,
  input wire logic reset,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic periph_req,
  input wire logic system_off,
  input wire logic slow_clock,
  output logic periph_32k_clock,
  output logic slow_req,
  output logic [1:0] slow_req_source,
  output logic keep_running,
  output logic fast_clock_req,
  output logic cal_req,
  input wire logic slow_running,
  input wire logic [1:0] slow_running_source,
  input wire logic cal_done_toggle,
  input wire logic src_change_toggle,
  output logic started_flag,
  output logic done_flag
);
  // ****************************************
  // input crossing
  // ****************************************
  logic [4:0] sync_q;
  logic run_s;
  logic [1:0] run_src_s;
  logic done_tg_s;
  logic chg_tg_s;
  logic done_tg_q;
  logic chg_tg_q;
  logic done_pulse;
  logic chg_pulse;

  lfc_sync #(.W(5)) u_sync (
    .clock(clock),
    .reset(reset),
    .d({src_change_toggle, cal_done_toggle, slow_running_source, slow_running}),
    .q(sync_q)
  );

  assign run_s = sync_q[0];
  assign run_src_s = sync_q[2:1];
  assign done_tg_s = sync_q[3];
  assign chg_tg_s = sync_q[4];

  always_ff @(posedge clock) begin
    if (reset) begin
      done_tg_q <= 1'b0;
      chg_tg_q <= 1'b0;
    end else begin
      done_tg_q <= done_tg_s;
      chg_tg_q <= chg_tg_s;
    end
  end

  assign done_pulse = done_tg_s ^ done_tg_q;
  assign chg_pulse = chg_tg_s ^ chg_tg_q;

  // ****************************************
  // bus slave: one wait cycle per access
  // ****************************************
  logic ack_q;
  logic wr_go;
  logic rd_go;

  assign waitrequest = (read | write) & ~ack_q;
  assign wr_go = write & ack_q;
  assign rd_go = read & ~ack_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  logic start_task;
  logic stop_task;
  logic cal_task;
  logic clr_started;
  logic clr_done;

  assign start_task = wr_go & (address == lfc_pkg::OFS_START_TASK) & writedata[lfc_pkg::TASK_BIT];
  assign stop_task = wr_go & (address == lfc_pkg::OFS_STOP_TASK) & writedata[lfc_pkg::TASK_BIT];
  assign cal_task = wr_go & (address == lfc_pkg::OFS_CAL_TASK) & writedata[lfc_pkg::TASK_BIT];
  assign clr_started = wr_go & (address == lfc_pkg::OFS_STARTED_EVT)
                       & ~writedata[lfc_pkg::TASK_BIT];
  assign clr_done = wr_go & (address == lfc_pkg::OFS_DONE_EVT) & ~writedata[lfc_pkg::TASK_BIT];

  // ****************************************
  // configuration, applied only at start
  // ****************************************
  logic [1:0] src_sel_q;
  logic keep_sel_q;
  logic [1:0] src_latched_q;
  logic keep_active_q;
  logic started_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      src_sel_q <= lfc_pkg::SRC_RESET;
      keep_sel_q <= lfc_pkg::KEEP_RESET;
    end else if (wr_go && address == lfc_pkg::OFS_SRC_SELECT) begin
      src_sel_q <= writedata[lfc_pkg::SRC_LSB +: lfc_pkg::SRC_W];
    end else if (wr_go && address == lfc_pkg::OFS_KEEP_RUNNING) begin
      keep_sel_q <= writedata[0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      src_latched_q <= lfc_pkg::SRC_RESET;
      keep_active_q <= lfc_pkg::KEEP_RESET;
      started_q <= 1'b0;
    end else if (system_off) begin
      keep_active_q <= 1'b0;
      started_q <= 1'b0;
    end else if (start_task) begin
      // restart without stop is fine
      src_latched_q <= src_sel_q;
      keep_active_q <= keep_sel_q;
      started_q <= 1'b1;
    end else if (stop_task) begin
      keep_active_q <= 1'b0;
      started_q <= 1'b0;
    end
  end

  // ****************************************
  // requests toward the subsystem
  // ****************************************
  lfc_pkg::lfc_cal_t cal_q;

  // withdrawn request lets the subsystem stop the clock or fall back
  always_ff @(posedge clock) begin
    if (reset) begin
      slow_req <= 1'b0;
      slow_req_source <= lfc_pkg::SRC_RC;
      keep_running <= 1'b0;
      fast_clock_req <= 1'b0;
    end else begin
      slow_req <= (periph_req | started_q | keep_active_q) & ~system_off;
      slow_req_source <= started_q ? src_latched_q : lfc_pkg::SRC_RC;
      keep_running <= keep_active_q & ~system_off;
      fast_clock_req <= ~system_off & ((started_q & src_latched_q == lfc_pkg::SRC_SYNTH)
                        | cal_q == lfc_pkg::CAL_BUSY);
    end
  end

  // clock passes straight through; consumers must tolerate one lost period
  assign periph_32k_clock = slow_clock & ~system_off;

  // ****************************************
  // started event
  // ****************************************
  logic pending_q;
  logic src_ok;
  logic started_set;

  // crystal counts as up only when the subsystem reports crystal or synth, not rc
  assign src_ok = run_s & (run_src_s >= src_latched_q);
  assign started_set = pending_q & src_ok & ~start_task;

  always_ff @(posedge clock) begin
    if (reset) begin
      pending_q <= 1'b0;
    end else if (system_off) begin
      pending_q <= 1'b0;
    end else if (start_task) begin
      pending_q <= 1'b1;
    end else if (started_set) begin
      pending_q <= 1'b0;
    end
  end

  logic started_flag_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      started_flag_q <= 1'b0;
    end else if (started_set) begin
      started_flag_q <= 1'b1;
    end else if (clr_started) begin
      started_flag_q <= 1'b0;
    end
  end

  assign started_flag = started_flag_q;

  // ****************************************
  // calibration
  // ****************************************
  logic own_src_change;
  logic done_set;

  assign own_src_change = start_task & (src_sel_q != src_latched_q);
  assign done_set = cal_q == lfc_pkg::CAL_BUSY & done_pulse & ~chg_pulse & ~own_src_change;

  always_ff @(posedge clock) begin
    if (reset) begin
      cal_q <= lfc_pkg::CAL_IDLE;
    end else if (system_off) begin
      cal_q <= lfc_pkg::CAL_IDLE;
    end else begin
      unique case (cal_q)
        lfc_pkg::CAL_IDLE: begin
          if (cal_task) begin
            cal_q <= lfc_pkg::CAL_BUSY;
          end
        end
        lfc_pkg::CAL_BUSY: begin
          // a retrigger here has no effect
          if (chg_pulse || own_src_change || done_pulse) begin
            cal_q <= lfc_pkg::CAL_IDLE;
          end
        end
        default: begin
          cal_q <= lfc_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  assign cal_req = cal_q == lfc_pkg::CAL_BUSY;

  logic done_flag_q;

  // each instance flags only its own calibration
  always_ff @(posedge clock) begin
    if (reset) begin
      done_flag_q <= 1'b0;
    end else if (done_set) begin
      done_flag_q <= 1'b1;
    end else if (clr_done) begin
      done_flag_q <= 1'b0;
    end
  end

  assign done_flag = done_flag_q;

  // ****************************************
  // read mux
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      readdata <= 32'h0;
    end else if (rd_go) begin
      unique case (address)
        lfc_pkg::OFS_STARTED_EVT: readdata <= {31'h0, started_flag_q};
        lfc_pkg::OFS_DONE_EVT: readdata <= {31'h0, done_flag_q};
        lfc_pkg::OFS_START_STATUS: readdata <= {31'h0, started_q};
        lfc_pkg::OFS_RUN_STAT: readdata <= {15'h0, run_s, 14'h0, run_src_s};
        lfc_pkg::OFS_SRC_LATCHED: readdata <= {30'h0, src_latched_q};
        lfc_pkg::OFS_SRC_SELECT: readdata <= {30'h0, src_sel_q};
        lfc_pkg::OFS_KEEP_RUNNING: readdata <= {31'h0, keep_sel_q};
        default: readdata <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_start;
    start_task && !system_off;
  endsequence

  sequence s_cal_begin;
    cal_task && cal_q == lfc_pkg::CAL_IDLE && !system_off;
  endsequence

  a_start_copy: assert property (@(posedge clock) disable iff (reset)
    s_start |=> src_latched_q == $past(src_sel_q) && started_q)
    else $error("start did not copy source");

  a_periph_req: assert property (@(posedge clock) disable iff (reset)
    periph_req && !system_off |=> slow_req)
    else $error("peripheral need not requested");

  a_auto_rc: assert property (@(posedge clock) disable iff (reset)
    !started_q |=> slow_req_source == lfc_pkg::SRC_RC)
    else $error("automatic request not on rc");

  a_off_drops: assert property (@(posedge clock) disable iff (reset)
    system_off |=> !slow_req && !started_q && cal_q == lfc_pkg::CAL_IDLE)
    else $error("system off left a request");

  a_one_event: assert property (@(posedge clock) disable iff (reset)
    started_set |=> !pending_q)
    else $error("pending not consumed by event");

  a_event_cause: assert property (@(posedge clock) disable iff (reset)
    $rose(started_flag_q) |-> $past(pending_q) && $past(src_ok))
    else $error("started event without cause");

  a_cal_fast: assert property (@(posedge clock) disable iff (reset)
    s_cal_begin |=> cal_req ##1 fast_clock_req)
    else $error("calibration did not request fast clock");

  a_cal_abort: assert property (@(posedge clock) disable iff (reset)
    cal_q == lfc_pkg::CAL_BUSY && chg_pulse && !done_flag_q |=> !done_flag_q && !cal_req)
    else $error("aborted calibration flagged done");

  a_cal_ignore: assert property (@(posedge clock) disable iff (reset)
    cal_req && !done_pulse && !chg_pulse && !own_src_change && !system_off |=> cal_req)
    else $error("calibration dropped without cause");

  a_synth_fast: assert property (@(posedge clock) disable iff (reset)
    started_q && src_latched_q == lfc_pkg::SRC_SYNTH && !system_off |=> fast_clock_req)
    else $error("synthesized source lacks fast clock");

  a_bus_wait: assert property (@(posedge clock) disable iff (reset)
    (read || write) && !ack_q |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");
endmodule

/* verif/lfc_subsys_model.sv */
// Purpose: behavioural model of the shared power and clock subsystem
// Assumes: runs on the core clock; the controller synchronises its outputs
// Notes: crystal and synth warm up on rc first; another core is driven by the bench
module lfc_subsys_model #(
  parameter int XTAL_WAIT = 40,
  parameter int CAL_WAIT = 60,
  parameter int HALF = 3
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic slow_req,
  input wire logic [1:0] slow_req_source,
  input wire logic keep_running,
  input wire logic fast_clock_req,
  input wire logic cal_req,
  input wire logic other_req,
  input wire logic [1:0] other_source,
  input wire logic change_pulse,
  output logic slow_clock,
  output logic slow_running,
  output logic [1:0] slow_running_source,
  output logic cal_done_toggle,
  output logic src_change_toggle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic need;
  logic [1:0] want;
  logic [1:0] want_q;
  int warm_q;
  int div_q;
  int cal_q;

  always_comb begin
    need = slow_req | keep_running | other_req;
    want = (slow_req | keep_running) ? slow_req_source : 2'h0;
    if (other_req && other_source > want) begin
      want = other_source;
    end
  end

  // any change of wanted source restarts warm-up, running on rc meanwhile
  always_ff @(posedge clock) begin
    if (reset || !need) begin
      slow_running <= 1'b0;
      slow_running_source <= 2'h0;
      warm_q <= 0;
      want_q <= 2'h0;
    end else begin
      slow_running <= 1'b1;
      want_q <= want;
      warm_q <= (want != want_q) ? 0 : warm_q + 1;
      slow_running_source <= (warm_q >= XTAL_WAIT) ? want_q : 2'h0;
    end
  end

  // clock stands still at 0 while nothing runs
  always_ff @(posedge clock) begin
    if (reset || !slow_running) begin
      div_q <= 0;
      slow_clock <= 1'b0;
    end else if (div_q == HALF - 1) begin
      div_q <= 0;
      slow_clock <= ~slow_clock;
    end else begin
      div_q <= div_q + 1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cal_q <= 0;
      cal_done_toggle <= 1'b0;
      src_change_toggle <= 1'b0;
    end else begin
      if (change_pulse) begin
        src_change_toggle <= ~src_change_toggle;
      end
      if (!(cal_req && fast_clock_req)) begin
        cal_q <= 0;
      end else if (cal_q == CAL_WAIT) begin
        cal_q <= 0;
        cal_done_toggle <= ~cal_done_toggle;
      end else begin
        cal_q <= cal_q + 1;
      end
    end
  end
endmodule

/* verif/lfc_ctrl_tb_top.sv */
// Purpose: self-checking bench for the slow clock controller
// Assumes: subsystem model on the same clock, bench plays the other core
// Notes: main flow rests on falling edges; inputs move just after rising edges
module lfc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, read, write, periph_req, system_off, other_req, change_pulse;
  logic [11:0] address;
  logic [31:0] writedata, readdata, q;
  logic [1:0] other_source, slow_req_source, slow_running_source;
  logic waitrequest, slow_clock, periph_32k_clock, slow_req, keep_running, fast_clock_req;
  logic cal_req, slow_running, cal_done_toggle, src_change_toggle, started_flag, done_flag;
  int bad_count, samples_checked;

  lfc_ctrl u_lfc_ctrl (.clock(clock), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .periph_req(periph_req), .system_off(system_off), .slow_clock(slow_clock),
    .periph_32k_clock(periph_32k_clock), .slow_req(slow_req),
    .slow_req_source(slow_req_source), .keep_running(keep_running),
    .fast_clock_req(fast_clock_req), .cal_req(cal_req), .slow_running(slow_running),
    .slow_running_source(slow_running_source), .cal_done_toggle(cal_done_toggle),
    .src_change_toggle(src_change_toggle), .started_flag(started_flag),
    .done_flag(done_flag));
  lfc_subsys_model u_lfc_subsys_model (.clock(clock), .reset(reset), .slow_req(slow_req),
    .slow_req_source(slow_req_source), .keep_running(keep_running),
    .fast_clock_req(fast_clock_req), .cal_req(cal_req), .other_req(other_req),
    .other_source(other_source), .change_pulse(change_pulse), .slow_clock(slow_clock),
    .slow_running(slow_running), .slow_running_source(slow_running_source),
    .cal_done_toggle(cal_done_toggle), .src_change_toggle(src_change_toggle));

  always #10 clock = ~clock;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus_op(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic w;
    int n;
    w = 1'b1;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    // values seen right after the edge are those that the edge sampled
    while (w !== 1'b0 && n < 20) begin
      @(posedge clock);
      w = waitrequest;
      q = readdata;
      n++;
    end
    write <= 1'b0;
    read <= 1'b0;
    @(negedge clock);
    if (w !== 1'b0) begin
      bad_count++;
      complete_run();
    end
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus_op(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask

  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int n = 0; n < lim && s !== v; n++) begin
      @(negedge clock);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values();
    logic [11:0] offs [7];
    offs = '{lfc_pkg::OFS_START_STATUS, lfc_pkg::OFS_SRC_LATCHED, lfc_pkg::OFS_SRC_SELECT,
      lfc_pkg::OFS_KEEP_RUNNING, lfc_pkg::OFS_STARTED_EVT, lfc_pkg::OFS_DONE_EVT, 12'hFF0};
    foreach (offs[i]) begin
      rd_chk("reset read", offs[i], 32'h0);
    end
  endtask

  task automatic t_auto_request();
    @(posedge clock);
    periph_req <= 1'b1;
    wait_for(slow_req, 1'b1, 10);
    chk("auto req", {29'h0, slow_req, slow_req_source}, {29'h0, 1'b1, lfc_pkg::SRC_RC});
    wait_for(slow_clock, 1'b1, 40);
    repeat (12) begin
      chk("core clock", {31'h0, periph_32k_clock}, {31'h0, slow_clock});
      @(negedge clock);
    end
    chk("no started", {31'h0, started_flag}, 32'h0);
    @(posedge clock);
    periph_req <= 1'b0;
    wait_for(slow_req, 1'b0, 10);
    chk("req dropped", {31'h0, slow_req}, 32'h0);
  endtask

  task automatic t_xtal_start();
    bus_op(1'b1, lfc_pkg::OFS_SRC_SELECT, {30'h0, lfc_pkg::SRC_XTAL});
    bus_op(1'b1, lfc_pkg::OFS_START_TASK, 32'h1);
    rd_chk("start status", lfc_pkg::OFS_START_STATUS, 32'h1);
    rd_chk("latched", lfc_pkg::OFS_SRC_LATCHED, {30'h0, lfc_pkg::SRC_XTAL});
    chk("req source", {30'h0, slow_req_source}, {30'h0, lfc_pkg::SRC_XTAL});
    wait_for(slow_running, 1'b1, 20);
    repeat (8) @(negedge clock);
    chk("early started", {31'h0, started_flag}, 32'h0);
    wait_for(started_flag, 1'b1, 200);
    rd_chk("started evt", lfc_pkg::OFS_STARTED_EVT, 32'h1);
    rd_chk("run stat", lfc_pkg::OFS_RUN_STAT, 32'h0001_0001);
    bus_op(1'b1, lfc_pkg::OFS_STARTED_EVT, 32'h0);
    rd_chk("cleared", lfc_pkg::OFS_STARTED_EVT, 32'h0);
  endtask

  task automatic t_repeat_start();
    bus_op(1'b1, lfc_pkg::OFS_STOP_TASK, 32'h1);
    wait_for(slow_running, 1'b0, 20);
    rd_chk("stopped", lfc_pkg::OFS_START_STATUS, 32'h0);
    chk("stop req", {31'h0, slow_req}, 32'h0);
    bus_op(1'b1, lfc_pkg::OFS_START_TASK, 32'h1);
    bus_op(1'b1, lfc_pkg::OFS_START_TASK, 32'h1);
    wait_for(started_flag, 1'b1, 200);
    bus_op(1'b1, lfc_pkg::OFS_STARTED_EVT, 32'h0);
    repeat (80) @(negedge clock);
    chk("single event", {31'h0, started_flag}, 32'h0);
    bus_op(1'b1, lfc_pkg::OFS_START_TASK, 32'h1);
    wait_for(started_flag, 1'b1, 40);
    chk("new event", {31'h0, started_flag}, 32'h1);
    bus_op(1'b1, lfc_pkg::OFS_STARTED_EVT, 32'h0);
  endtask

  task automatic t_select_apply();
    @(posedge clock);
    other_source <= lfc_pkg::SRC_SYNTH;
    other_req <= 1'b1;
    for (int n = 0; n < 200 && slow_running_source !== lfc_pkg::SRC_SYNTH; n++) begin
      @(negedge clock);
    end
    repeat (8) @(negedge clock);
    rd_chk("best source", lfc_pkg::OFS_RUN_STAT, 32'h0001_0002);
    @(posedge clock);
    other_req <= 1'b0;
    repeat (10) @(negedge clock);
    for (int n = 0; n < 200 && slow_running_source !== lfc_pkg::SRC_XTAL; n++) begin
      @(negedge clock);
    end
    repeat (8) @(negedge clock);
    rd_chk("fallback", lfc_pkg::OFS_RUN_STAT, 32'h0001_0001);
    bus_op(1'b1, lfc_pkg::OFS_SRC_SELECT, {30'h0, lfc_pkg::SRC_SYNTH});
    repeat (3) @(negedge clock);
    chk("not applied", {30'h0, slow_req_source}, {30'h0, lfc_pkg::SRC_XTAL});
    bus_op(1'b1, lfc_pkg::OFS_START_TASK, 32'h1);
    repeat (3) @(negedge clock);
    rd_chk("relatched", lfc_pkg::OFS_SRC_LATCHED, {30'h0, lfc_pkg::SRC_SYNTH});
    chk("synth fast", {29'h0, fast_clock_req, slow_req_source}, 32'h6);
    bus_op(1'b1, lfc_pkg::OFS_STOP_TASK, 32'h1);
    wait_for(fast_clock_req, 1'b0, 10);
    chk("fast off", {31'h0, fast_clock_req}, 32'h0);
  endtask

  task automatic t_calibrate();
    bus_op(1'b1, lfc_pkg::OFS_CAL_TASK, 32'h1);
    repeat (2) @(negedge clock);
    chk("cal on", {30'h0, cal_req, fast_clock_req}, 32'h3);
    bus_op(1'b1, lfc_pkg::OFS_CAL_TASK, 32'h1);
    chk("cal again", {30'h0, cal_req, done_flag}, 32'h2);
    wait_for(done_flag, 1'b1, 150);
    rd_chk("done evt", lfc_pkg::OFS_DONE_EVT, 32'h1);
    chk("cal ended", {31'h0, cal_req}, 32'h0);
    bus_op(1'b1, lfc_pkg::OFS_DONE_EVT, 32'h0);
    rd_chk("done clr", lfc_pkg::OFS_DONE_EVT, 32'h0);
    bus_op(1'b1, lfc_pkg::OFS_CAL_TASK, 32'h1);
    repeat (10) @(negedge clock);
    @(posedge clock);
    change_pulse <= 1'b1;
    @(posedge clock);
    change_pulse <= 1'b0;
    wait_for(cal_req, 1'b0, 20);
    repeat (100) @(negedge clock);
    chk("aborted", {30'h0, cal_req, done_flag}, 32'h0);
    // own start with a different source must abort as well
    bus_op(1'b1, lfc_pkg::OFS_CAL_TASK, 32'h1);
    bus_op(1'b1, lfc_pkg::OFS_SRC_SELECT, {30'h0, lfc_pkg::SRC_RC});
    bus_op(1'b1, lfc_pkg::OFS_START_TASK, 32'h1);
    repeat (100) @(negedge clock);
    chk("own abort", {30'h0, cal_req, done_flag}, 32'h0);
  endtask

  task automatic t_keep_and_off();
    bus_op(1'b1, lfc_pkg::OFS_KEEP_RUNNING, 32'h1);
    repeat (3) @(negedge clock);
    chk("keep idle", {31'h0, keep_running}, 32'h0);
    bus_op(1'b1, lfc_pkg::OFS_START_TASK, 32'h1);
    repeat (3) @(negedge clock);
    chk("keep on", {31'h0, keep_running}, 32'h1);
    wait_for(slow_clock, 1'b1, 40);
    @(posedge clock);
    periph_req <= 1'b1;
    system_off <= 1'b1;
    repeat (3) @(negedge clock);
    repeat (10) begin
      chk("off", {29'h0, slow_req, keep_running, periph_32k_clock}, 32'h0);
      @(negedge clock);
    end
    rd_chk("off status", lfc_pkg::OFS_START_STATUS, 32'h0);
  endtask

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 12'h000;
    writedata = 32'h0;
    periph_req = 1'b0;
    system_off = 1'b0;
    other_req = 1'b0;
    other_source = 2'h0;
    change_pulse = 1'b0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    t_reset_values();
    t_auto_request();
    t_xtal_start();
    t_repeat_start();
    t_select_apply();
    t_calibrate();
    t_keep_and_off();
    complete_run();
  end

  // the whole run needs about a thousand cycles
  initial begin
    #400000;
    bad_count++;
    complete_run();
  end
endmodule
